// ### cbl_regs.svh
// cbl_regs.svh: register offsets, fields, reset values, coefficients
// Assumes a 32-bit APB slave with word-aligned registers
`ifndef CBL_REGS_SVH
`define CBL_REGS_SVH
`define CBL_OFF_GEOM0   8'h00
`define CBL_OFF_GEOM1   8'h04
`define CBL_OFF_TARGET  8'h08
`define CBL_OFF_CMD     8'h0C
`define CBL_OFF_MAJOR   8'h10
`define CBL_OFF_MINOR   8'h14
`define CBL_OFF_START   8'h18
`define CBL_OFF_WORDPOS 8'h1C
`define CBL_OFF_PAD     8'h20
`define CBL_OFF_IOCAP   8'h24
`define CBL_OFF_ADJ     8'h28
`define CBL_F_COLS  7:0
`define CBL_F_ROWS  15:8
`define CBL_F_RAMS  23:16
`define CBL_F_SPACE 31:24
`define CBL_F_FLEN  7:0
`define CBL_B_EXT   8
`define CBL_F_COL   7:0
`define CBL_F_ROW   15:8
`define CBL_B_SLICE 16
`define CBL_B_LUT   17
`define CBL_B_FLOP  18
`define CBL_B_RW    19
`define CBL_B_KIND  20
`define CBL_F_TBIT  27:24
`define CBL_B_START 0
`define CBL_B_CAPT  1
`define CBL_B_CLR   2
`define CBL_F_PAD   15:0
`define CBL_RST_GEOM0 32'h0604_1018
`define CBL_RST_GEOM1 32'h0000_000C
`define CBL_RST_ZERO  32'h0000_0000
`define CBL_K_ROWBITS 32'sh12
`define CBL_K_WORD    32'sh20
`define CBL_K_LUTSL   32'sh11
`define CBL_K_LUTBIT  32'sh3
`define CBL_K_FF12    32'shC
`define CBL_K_FF43    32'sh2B
`define CBL_K_FF6     32'sh6
`define CBL_K_FF45    32'sh2D
`define CBL_K_ST8     32'sh8
`define CBL_K_ST48    32'sh30
`define CBL_K_ADJ27   32'sh1B
`define CBL_LATENCY   2
`endif

// ### cbl_pkg.sv
// cbl_pkg: shared types of the bit locator
// Assumes nothing beyond a SystemVerilog compiler
package cbl_pkg;
  typedef logic signed [31:0] cbl_sword_t;
  // Gray order around the die
  typedef enum logic [1:0] {
    CBL_EDGE_TOP    = 2'h0,
    CBL_EDGE_RIGHT  = 2'h1,
    CBL_EDGE_BOTTOM = 2'h3,
    CBL_EDGE_LEFT   = 2'h2
  } cbl_edge_e;
  typedef enum logic {
    CBL_KIND_LUT  = 1'h0,
    CBL_KIND_FLOP = 1'h1
  } cbl_kind_e;
endpackage : cbl_pkg

// ### cbl_pad_ranger.sv
// cbl_pad_ranger: pad index to die edge and column
// Assumes geometry and index are stable register outputs
`timescale 1ns/100ps
`default_nettype none
module cbl_pad_ranger (
  input  wire logic [7:0]        cols,
  input  wire logic [7:0]        rows,
  input  wire logic [15:0]       pad_index,
  output cbl_pkg::cbl_edge_e     pad_edge,
  output logic                   in_range,
  output logic [7:0]             pad_column
);
  cbl_pkg::cbl_sword_t i_s;
  cbl_pkg::cbl_sword_t c2;
  cbl_pkg::cbl_sword_t r3;
  cbl_pkg::cbl_sword_t bot_hi;
  cbl_pkg::cbl_sword_t col_s;
  assign i_s    = $signed({16'h0000, pad_index});
  assign c2     = $signed({23'h0, cols, 1'b0});
  assign r3     = $signed({24'h000000, rows}) * 32'sh3;
  assign bot_hi = c2 + c2 + r3;
  // Clockwise ranges, two per column end, three per row
  assign in_range = (i_s >= 32'sh1) && (i_s <= bot_hi + r3);
  assign pad_edge = (i_s <= c2)      ? cbl_pkg::CBL_EDGE_TOP :
                    (i_s <= c2 + r3) ? cbl_pkg::CBL_EDGE_RIGHT :
                    (i_s <= bot_hi)  ? cbl_pkg::CBL_EDGE_BOTTOM :
                                       cbl_pkg::CBL_EDGE_LEFT;
  // Pad 1 sits above column 1; bottom counts back
  assign col_s = (pad_edge == cbl_pkg::CBL_EDGE_TOP) ?
                   (i_s + 32'sh1) >>> 1 :
                 (pad_edge == cbl_pkg::CBL_EDGE_BOTTOM) ?
                   (bot_hi + 32'sh2 - i_s) >>> 1 :
                   32'sh0;
  assign pad_column = in_range ? col_s[7:0] : 8'h00;
endmodule : cbl_pad_ranger
`default_nettype wire

// ### cbl_locator.sv
// cbl_locator: configuration bit locator behind an APB slave
// Assumes APB master on clk_sys; io_cap_in is asynchronous
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "cbl_regs.svh"
module cbl_locator (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  io_cap_in,
  output logic             result_valid
);
  typedef cbl_pkg::cbl_sword_t sw_t;

  function automatic sw_t ceil_div(input sw_t n, input sw_t d);
    sw_t q;
    q = n / d;
    if ((n % d != 32'sh0) && (n > 32'sh0))
      q = q + 32'sh1;
    return q;
  endfunction : ceil_div

  logic [31:0] geom0_q;
  logic [31:0] geom1_q;
  logic [31:0] target_q;
  logic [15:0] pad_q;
  logic [3:0]  cap_s1_q;
  logic [3:0]  cap_s2_q;
  logic [3:0]  cap_q;
  logic        s1_q;
  logic        rv_q;
  logic        done_q;
  logic [31:0] prdata_q;
  sw_t         majb_q;
  sw_t         minb_q;
  sw_t         bif_q;
  sw_t         adj_q;
  sw_t         flen_q;
  sw_t         rw_q;
  sw_t         major_q;
  sw_t         minor_q;
  sw_t         start_q;
  logic [7:0]  word_q;
  logic [4:0]  biw_q;
  logic [15:0] bifo_q;

  wire access   = psel & penable;
  wire setup_rd = psel & ~penable & ~pwrite;
  wire wr       = access & pwrite;
  wire hit_g0   = paddr == `CBL_OFF_GEOM0;
  wire hit_g1   = paddr == `CBL_OFF_GEOM1;
  wire hit_tg   = paddr == `CBL_OFF_TARGET;
  wire hit_cmd  = paddr == `CBL_OFF_CMD;
  wire hit_pad  = paddr == `CBL_OFF_PAD;
  wire hit_ro   = (paddr == `CBL_OFF_MAJOR) |
                  (paddr == `CBL_OFF_MINOR) |
                  (paddr == `CBL_OFF_START) |
                  (paddr == `CBL_OFF_WORDPOS) |
                  (paddr == `CBL_OFF_IOCAP) |
                  (paddr == `CBL_OFF_ADJ);
  wire hit      = hit_g0 | hit_g1 | hit_tg | hit_cmd |
                  hit_pad | hit_ro;
  wire start    = wr & hit_cmd & pwdata[`CBL_B_START];
  wire capt     = wr & hit_cmd & pwdata[`CBL_B_CAPT];
  wire clr_done = wr & hit_cmd & pwdata[`CBL_B_CLR];

  assign pready  = 1'b1;
  assign pslverr = access & ~hit;

  // Signed views of geometry and target
  wire sw_t cols  = $signed({24'h0, geom0_q[`CBL_F_COLS]});
  wire sw_t rams  = $signed({24'h0, geom0_q[`CBL_F_RAMS]});
  wire sw_t space = $signed({24'h0, geom0_q[`CBL_F_SPACE]});
  wire sw_t flen  = $signed({24'h0, geom1_q[`CBL_F_FLEN]});
  wire sw_t col   = $signed({24'h0, target_q[`CBL_F_COL]});
  wire sw_t row   = $signed({24'h0, target_q[`CBL_F_ROW]});
  wire sw_t lb    = $signed({28'h0, target_q[`CBL_F_TBIT]});
  wire sw_t sl    = $signed({31'h0, target_q[`CBL_B_SLICE]});
  wire sw_t lsel  = $signed({31'h0, target_q[`CBL_B_LUT]});
  wire sw_t fsel  = $signed({31'h0, target_q[`CBL_B_FLOP]});
  wire sw_t rw    = $signed({31'h0, target_q[`CBL_B_RW]});
  wire      ext   = geom1_q[`CBL_B_EXT];
  wire cbl_pkg::cbl_kind_e kind =
    cbl_pkg::cbl_kind_e'(target_q[`CBL_B_KIND]);

  // Left half when column is at most half the columns
  wire      left     = (col + col) <= cols;
  wire sw_t maj_base = left ? cols - col - col + 32'sh2
                            : col + col - cols - 32'sh1;

  wire sw_t min_lut = lb + `CBL_K_WORD -
                      sl * (lb + lb + `CBL_K_LUTSL);
  wire sw_t min_ff  = sl * (`CBL_K_FF12 * fsel - `CBL_K_FF43) -
                      `CBL_K_FF6 * fsel + `CBL_K_FF45;
  wire sw_t min_sel = (kind == cbl_pkg::CBL_KIND_FLOP) ?
                      min_ff : min_lut;

  // Frame bits numbered from zero, continuing across words
  wire sw_t row_bits = `CBL_K_ROWBITS * row;
  wire sw_t bif_lut  = `CBL_K_LUTBIT + row_bits - lsel +
                       rw * `CBL_K_WORD;
  wire sw_t bif_ff   = row_bits + 32'sh1 +
                       rw * `CBL_K_WORD;
  wire sw_t bif      = (kind == cbl_pkg::CBL_KIND_FLOP) ?
                       bif_ff : bif_lut;

  // Memory column boundary, shared by both target kinds
  wire sw_t half_m1 = (rams >>> 1) - 32'sh1;
  wire sw_t bnd_l   = half_m1 * space;
  wire sw_t bnd_r   = cols - bnd_l + 32'sh1;
  wire sw_t adj_num = left ? bnd_l - col + 32'sh1
                           : col - bnd_r + 32'sh1;
  wire      adj_ok  = ext && (space != 32'sh0);
  // Exact ceiling, also for negative numerators
  wire sw_t adj     = adj_ok ? 32'sh2 * ceil_div(adj_num, space)
                             : 32'sh0;

  // Second stage uses only base values from stage one
  wire sw_t st_base = flen_q * (`CBL_K_ST8 +
                      (majb_q - 32'sh1) * `CBL_K_ST48 + minb_q) +
                      rw_q * flen_q;
  wire sw_t st_adj  = flen_q * (`CBL_K_ADJ27 * adj_q);
  wire sw_t maj_fin = majb_q + adj_q;
  wire sw_t word_s  = bif_q >>> 5;
  wire sw_t biw_s   = 32'sh1F + `CBL_K_WORD * word_s -
                      bif_q;

  cbl_pkg::cbl_edge_e pad_edge;
  logic               pad_ok;
  logic [7:0]         pad_col;

  cbl_pad_ranger u_pad (
    .cols       (geom0_q[`CBL_F_COLS]),
    .rows       (geom0_q[`CBL_F_ROWS]),
    .pad_index  (pad_q),
    .pad_edge   (pad_edge),
    .in_range   (pad_ok),
    .pad_column (pad_col)
  );

  wire [31:0] rd_mux =
    hit_g0 ? geom0_q :
    hit_g1 ? geom1_q :
    hit_tg ? target_q :
    hit_cmd ? {30'h0, s1_q, done_q} :
    (paddr == `CBL_OFF_MAJOR) ? major_q :
    (paddr == `CBL_OFF_MINOR) ? minor_q :
    (paddr == `CBL_OFF_START) ? start_q :
    (paddr == `CBL_OFF_WORDPOS) ?
      {bifo_q, 3'h0, biw_q, word_q} :
    hit_pad ? {pad_col, 5'h0, pad_ok, pad_edge, pad_q} :
    (paddr == `CBL_OFF_IOCAP) ? {28'h0, cap_q} :
    (paddr == `CBL_OFF_ADJ) ? adj_q :
    32'h0000_0000;

  assign prdata       = prdata_q;
  assign result_valid = rv_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      geom0_q  <= `CBL_RST_GEOM0;
      geom1_q  <= `CBL_RST_GEOM1;
      target_q <= `CBL_RST_ZERO;
      pad_q    <= 16'h0001;
      prdata_q <= `CBL_RST_ZERO;
    end else begin
      if (wr && hit_g0)
        geom0_q <= pwdata;
      if (wr && hit_g1)
        geom1_q <= {23'h0, pwdata[8:0]};
      if (wr && hit_tg)
        target_q <= {4'h0, pwdata[27:0]};
      if (wr && hit_pad)
        pad_q <= pwdata[`CBL_F_PAD];
      if (setup_rd)
        prdata_q <= rd_mux;
    end
  end

  // Two-flop synchroniser, then capture on command
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cap_s1_q <= 4'h0;
      cap_s2_q <= 4'h0;
      cap_q    <= 4'h0;
    end else begin
      cap_s1_q <= io_cap_in;
      cap_s2_q <= cap_s1_q;
      if (capt)
        cap_q <= cap_s2_q;
    end
  end

  // Stage one: base values of the request
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1_q   <= 1'b0;
      majb_q <= 32'sh0;
      minb_q <= 32'sh0;
      bif_q  <= 32'sh0;
      adj_q  <= 32'sh0;
      flen_q <= 32'sh0;
      rw_q   <= 32'sh0;
    end else begin
      s1_q <= start;
      if (start) begin
        majb_q <= maj_base;
        minb_q <= min_sel;
        bif_q  <= bif;
        adj_q  <= adj;
        flen_q <= flen;
        rw_q   <= rw;
      end
    end
  end

  // Stage two: final location and result pulse
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rv_q    <= 1'b0;
      major_q <= 32'sh0;
      minor_q <= 32'sh0;
      start_q <= 32'sh0;
      word_q  <= 8'h00;
      biw_q   <= 5'h00;
      bifo_q  <= 16'h0000;
    end else begin
      rv_q <= s1_q;
      if (s1_q) begin
        major_q <= maj_fin;
        minor_q <= minb_q;
        start_q <= st_base + st_adj;
        word_q  <= word_s[7:0];
        biw_q   <= biw_s[4:0];
        bifo_q  <= bif_q[15:0];
      end
    end
  end

  // Completion flag; a new result wins over a clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      done_q <= 1'b0;
    else if (rv_q)
      done_q <= 1'b1;
    else if (clr_done)
      done_q <= 1'b0;
  end

  // Checks
  sw_t base_h_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      base_h_q <= 32'sh0;
    else if (s1_q)
      base_h_q <= st_base;
  end

  property p_latency;
    @(posedge clk_sys) disable iff (rst)
    start |-> ##`CBL_LATENCY rv_q;
  endproperty
  a_latency: assert property (p_latency)
    else $error("result pulse not two cycles after start");

  property p_pulse;
    @(posedge clk_sys) disable iff (rst)
    rv_q |=> !rv_q;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("result pulse longer than one cycle");

  property p_major_sum;
    @(posedge clk_sys) disable iff (rst)
    start && left |=> majb_q + col + col == cols + 32'sh2;
  endproperty
  a_major_sum: assert property (p_major_sum)
    else $error("left half major address wrong");

  property p_ff_bit;
    @(posedge clk_sys) disable iff (rst)
    start && kind == cbl_pkg::CBL_KIND_FLOP |=>
      (bif_q - rw_q * 32'sh20 - 32'sh1) % 32'sh12 == 32'sh0;
  endproperty
  a_ff_bit: assert property (p_ff_bit)
    else $error("flop frame bit not on row grid");

  property p_word_split;
    @(posedge clk_sys) disable iff (rst)
    rv_q |-> {word_q, 5'h1F - biw_q} == bifo_q[12:0];
  endproperty
  a_word_split: assert property (p_word_split)
    else $error("word and bit do not rebuild frame bit");

  property p_major_fin;
    @(posedge clk_sys) disable iff (rst)
    s1_q |=> major_q == $past(majb_q) + $past(adj_q);
  endproperty
  a_major_fin: assert property (p_major_fin)
    else $error("final major is not base plus correction");

  property p_start_adj;
    @(posedge clk_sys) disable iff (rst)
    rv_q |-> start_q - base_h_q ==
             flen_q * 32'sh1B * adj_q;
  endproperty
  a_start_adj: assert property (p_start_adj)
    else $error("start word correction wrong");

  property p_no_adj;
    @(posedge clk_sys) disable iff (rst)
    start && !ext |=> adj_q == 32'sh0;
  endproperty
  a_no_adj: assert property (p_no_adj)
    else $error("correction applied outside extended variant");

  property p_done_set;
    @(posedge clk_sys) disable iff (rst)
    rv_q |=> done_q;
  endproperty
  a_done_set: assert property (p_done_set)
    else $error("done flag lost a result");

  property p_pad_range;
    @(posedge clk_sys) disable iff (rst)
    pad_q == 16'h0001 && geom0_q[7:0] != 8'h00 |->
      pad_ok && pad_edge == cbl_pkg::CBL_EDGE_TOP &&
      pad_col == 8'h01;
  endproperty
  a_pad_range: assert property (p_pad_range)
    else $error("pad one not above first column");

  c_lut_read: cover property (@(posedge clk_sys)
    start && kind == cbl_pkg::CBL_KIND_LUT && rw == 32'sh1);
  c_ff_ext: cover property (@(posedge clk_sys)
    start && kind == cbl_pkg::CBL_KIND_FLOP && ext);
  c_right: cover property (@(posedge clk_sys) start && !left);
  c_clr_race: cover property (@(posedge clk_sys)
    rv_q && clr_done);
endmodule : cbl_locator
`default_nettype wire

// ### cbl_requester.sv
// cbl_requester: APB master standing in for the locate requester
// Assumes an APB slave on clk_sys that may add wait states
`timescale 1ns/100ps
`default_nettype none
module cbl_requester (
  input  wire logic        clk_sys,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // Target word: direction, selects and bit index kept in range
  function automatic logic [31:0] target(input logic [7:0] col, row,
    input logic slice, lut, flop, rnw, kind, input logic [3:0] tbit);
    return {4'h0, tbit, 3'h0, kind, rnw, flop, lut, slice, row,
            col};
  endfunction : target

  task automatic xfer(input logic wr, input logic [7:0] addr,
                      input logic [31:0] wdata, output logic [31:0] rdata,
                      output logic err);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rdata = prdata;
    err   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released data must not look valid
    pwdata  <= ~wdata;
  endtask : xfer
endmodule : cbl_requester
`default_nettype wire

// ### config_bit_locator_test.sv
// config_bit_locator_test: self-checking bench of the bit locator
// Assumes cbl_locator and cbl_requester are compiled before it
`timescale 1ns/100ps
`default_nettype none
module config_bit_locator_test;
  logic        clk_sys;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  io_cap_in;
  logic        result_valid;
  logic [31:0] rdat;
  logic        rerr;
  int          num_errors;
  int          checks_done;
  int          c, mj, mn, adj, bif, s, f;
  int          cols[4] = '{1, 6, 7, 13};
  logic [15:0] pidx[7] = '{16'h0001, 16'h0030, 16'h0031, 16'h0060,
                           16'h0061, 16'h0090, 16'h00C0};
  logic [31:0] pexp[7] = '{32'h0104_0001, 32'h1804_0030, 32'h0005_0031,
                           32'h0005_0060, 32'h1807_0061, 32'h0107_0090,
                           32'h0006_00C0};
  logic [3:0]  caps[2] = '{4'hA, 4'h5};

`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  num_errors++; $display("BAD %s exp %h got %h", nm, e, g); end end

  cbl_locator DUT (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .io_cap_in(io_cap_in), .result_valid(result_valid));
  cbl_requester REQ (.clk_sys(clk_sys), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  initial clk_sys = 1'b0;
  always #4 clk_sys = ~clk_sys;

  function automatic logic [31:0] pos(input int b);
    return {b[15:0], 3'h0, 5'(31 + 32 * (b / 32) - b), 8'(b / 32)};
  endfunction : pos

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    REQ.xfer(1'b1, a, d, rdat, rerr);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input string nm);
    REQ.xfer(1'b0, a, 32'h0000_0000, rdat, rerr);
    `CHK(nm, e, rdat)
  endtask : rd_chk

  task automatic locate(input logic [31:0] g1, input logic [31:0] tgt);
    wr(8'h04, g1);
    wr(8'h08, tgt);
    wr(8'h0C, 32'h0000_0001);
    @(negedge clk_sys);
    `CHK("pulse_early", 1'b0, result_valid)
    @(negedge clk_sys);
    `CHK("pulse", 1'b1, result_valid)
    @(negedge clk_sys);
    `CHK("pulse_late", 1'b0, result_valid)
  endtask : locate

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (5000) @(posedge clk_sys);
    num_errors++;
    end_sim();
  end

  initial begin
    rst = 1'b1;
    io_cap_in = 4'h0;
    num_errors = 0;
    checks_done = 0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    rd_chk(8'h00, 32'h0604_1018, "geom0");
    rd_chk(8'h04, 32'h0000_000C, "geom1");
    rd_chk(8'h10, 32'h0000_0000, "major_rst");
    REQ.xfer(1'b0, 8'h30, 32'h0000_0000, rdat, rerr);
    `CHK("unmapped_err", 1'b1, rerr)
    `CHK("unmapped_data", 32'h0000_0000, rdat)
    $display("test reset done");

    // Table bit, left half, read, second slice and table
    bif = 3 + 18 * 2 - 1 + 32;
    locate(32'h0000_000C, REQ.target(8'h03, 8'h02, 1'b1, 1'b1, 1'b0,
                                     1'b1, 1'b0, 4'h5));
    rd_chk(8'h10, 24 - 3 * 2 + 2, "major");
    rd_chk(8'h14, 5 + 32 - (2 * 5 + 17), "minor");
    rd_chk(8'h18, 12 * (8 + 19 * 48 + 10) + 12, "start");
    rd_chk(8'h1C, pos(bif), "wordpos");
    rd_chk(8'h28, 32'h0000_0000, "adj_off");
    rd_chk(8'h0C, 32'h0000_0001, "done");
    wr(8'h0C, 32'h0000_0004);
    rd_chk(8'h0C, 32'h0000_0000, "done_clr");
    // Same table bit located for the write back of the frame
    locate(32'h0000_000C, REQ.target(8'h03, 8'h02, 1'b1, 1'b1, 1'b0,
                                     1'b0, 1'b0, 4'h5));
    rd_chk(8'h18, 12 * (8 + 19 * 48 + 10), "start_wr");
    rd_chk(8'h1C, pos(bif - 32), "wordpos_wr");
    $display("test table bit done");

    // Flop targets, right half, extended, all slice and flop pairs
    for (int k = 0; k < 4; k++) begin
      s = k / 2;
      f = k % 2;
      mn = s * (12 * f - 43) - 6 * f + 45;
      bif = 18 * 15 + 1 + 32 * f;
      locate(32'h0000_010C, REQ.target(8'd20, 8'd15, s[0], 1'b0, f[0],
                                       f[0], 1'b1, 4'h0));
      rd_chk(8'h28, 2, "ff_adj");
      rd_chk(8'h10, 2 * 20 - 24 - 1 + 2, "ff_major");
      rd_chk(8'h14, mn, "ff_minor");
      rd_chk(8'h18, 12 * (8 + 14 * 48 + mn) + 12 * f + 12 * 27 * 2,
             "ff_start");
      rd_chk(8'h1C, pos(bif), "ff_pos");
    end
    $display("test flop done");

    // Memory column correction across the ceiling boundaries
    foreach (cols[i]) begin
      c = cols[i];
      mj = (2 * c <= 24) ? 24 - 2 * c + 2 : 2 * c - 24 - 1;
      adj = (2 * c <= 24) ? 2 * ((6 - c + 1 + 5) / 6)
                          : 2 * ((c - 19 + 1 + 5) / 6);
      locate(32'h0000_010C, REQ.target(c[7:0], 8'h00, 1'b0, 1'b0, 1'b0,
                                       1'b0, 1'b0, 4'h0));
      rd_chk(8'h28, adj, "lut_adj");
      rd_chk(8'h10, mj + adj, "lut_major");
      rd_chk(8'h18, 12 * (8 + (mj - 1) * 48 + 32) + 12 * 27 * adj,
             "lut_start");
    end
    $display("test correction done");

    foreach (pidx[i]) begin
      wr(8'h20, {16'h0000, pidx[i]});
      rd_chk(8'h20, pexp[i], "pad");
    end
    wr(8'h20, 32'h0000_00C1);
    REQ.xfer(1'b0, 8'h20, 32'h0000_0000, rdat, rerr);
    `CHK("pad_out", 1'b0, rdat[18])
    $display("test pads done");

    foreach (caps[i]) begin
      @(posedge clk_sys);
      io_cap_in <= caps[i];
      repeat (3) @(posedge clk_sys);
      wr(8'h0C, 32'h0000_0002);
      rd_chk(8'h24, {28'h0000000, caps[i]}, "iocap");
    end
    $display("test capture done");
    end_sim();
  end
endmodule : config_bit_locator_test
`default_nettype wire
